/* rpt_core.v */
// repeater core: forwards one active port to all others, jams on collision
// assumes every port phy runs on sys_clk and presents a gmii-style byte stream
`timescale 1ns/1ps
`default_nettype none
`include "rpt_map.vh"

module rpt_core #(
  parameter NPORT = 4
) (
  input  wire               sys_clk,
  input  wire               srst,
  input  wire [NPORT-1:0]   rx_dv,
  input  wire [NPORT-1:0]   rx_er,
  input  wire [8*NPORT-1:0] rxd,
  output reg  [NPORT-1:0]   tx_en_q,
  output reg  [NPORT-1:0]   tx_er_q,
  output reg  [8*NPORT-1:0] txd_q,
  output reg  [NPORT-1:0]   fwd_only_q,
  output reg                collision_q,
  output reg                busy_q
);

  localparam IW = (NPORT > 1) ? $clog2(NPORT) : 1;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // true when two or more bits of the vector are set
  function multi;
    input [NPORT-1:0] v;
    integer           i;
    reg               seen;
    begin
      seen  = 1'b0;
      multi = 1'b0;
      for (i = 0; i < NPORT; i = i + 1) begin
        if (v[i] && seen) begin
          multi = 1'b1;
        end
        if (v[i]) begin
          seen = 1'b1;
        end
      end
    end
  endfunction

  // index of the lowest set bit
  function [IW-1:0] first_one;
    input [NPORT-1:0] v;
    integer           i;
    begin
      first_one = {IW{1'b0}};
      for (i = NPORT - 1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          first_one = i[IW-1:0];
        end
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // receive stage per port
  // --------------------------------------------------------------------------
  wire [NPORT-1:0]   dv;
  wire [NPORT-1:0]   er;
  wire [NPORT-1:0]   act;
  wire [8*NPORT-1:0] data;

  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_rx
      rpt_rx_port u_rx (
        .sys_clk (sys_clk),
        .srst    (srst),
        .rx_dv   (rx_dv[g]),
        .rx_er   (rx_er[g]),
        .rxd     (rxd[8*g +: 8]),
        .dv_q    (dv[g]),
        .er_q    (er[g]),
        .act_q   (act[g]),
        .data_q  (data[8*g +: 8])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  reg [1:0]    st_q;
  reg [1:0]    st_d;
  reg [IW-1:0] src_q;
  reg [IW-1:0] src_d;
  reg          cv_q;
  reg          cv_d;

  wire [NPORT-1:0] src_mask = {{(NPORT-1){1'b0}}, 1'b1} << src_q;
  wire             any_act  = |act;
  wire             src_dv   = dv[src_q];
  wire             src_er   = er[src_q];

  // collision stays declared until the medium falls quiet, so a packet torn by
  // a collision is never resumed mid-frame on the other ports
  always @* begin
    st_d  = st_q;
    src_d = src_q;
    cv_d  = cv_q;
    case (st_q)
      `RPT_ST_IDLE: begin
        cv_d = 1'b0;
        if (multi(act)) begin
          st_d = `RPT_ST_JAM;
        end else if (any_act) begin
          st_d  = `RPT_ST_FWD;
          src_d = first_one(act);
          cv_d  = dv[first_one(act)] & er[first_one(act)];
        end
      end
      `RPT_ST_FWD: begin
        if (|(act & ~src_mask)) begin
          st_d = `RPT_ST_JAM;
        end else if (!any_act) begin
          st_d = `RPT_ST_IDLE;
          cv_d = 1'b0;
        end else if (src_dv && src_er) begin
          cv_d = 1'b1;
        end
      end
      `RPT_ST_JAM: begin
        cv_d = 1'b0;
        if (!any_act) begin
          st_d = `RPT_ST_IDLE;
        end
      end
      default: begin
        st_d  = `RPT_ST_IDLE;
        src_d = {IW{1'b0}};
        cv_d  = 1'b0;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      st_q  <= `RPT_ST_IDLE;
      src_q <= {IW{1'b0}};
      cv_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      src_q <= src_d;
      cv_q  <= cv_d;
    end
  end

  // --------------------------------------------------------------------------
  // transmit
  // --------------------------------------------------------------------------
  // outputs follow the next state so start, jam start and jam end all see the
  // same fixed two-cycle path; preamble bytes pass untouched and unshortened
  reg [NPORT-1:0]   tx_en_d;
  reg [NPORT-1:0]   tx_er_d;
  reg [8*NPORT-1:0] txd_d;
  reg [NPORT-1:0]   dst_mask;
  integer           p;

  always @* begin
    tx_en_d  = {NPORT{1'b0}};
    tx_er_d  = {NPORT{1'b0}};
    txd_d    = {(8*NPORT){1'b0}};
    dst_mask = ~({{(NPORT-1){1'b0}}, 1'b1} << src_d);
    for (p = 0; p < NPORT; p = p + 1) begin
      if (st_d == `RPT_ST_JAM) begin
        tx_en_d[p]       = 1'b1;
        txd_d[8*p +: 8]  = `RPT_JAM_CODE;
      end else if (st_d == `RPT_ST_FWD && dst_mask[p]) begin
        if (cv_d) begin
          tx_en_d[p]      = 1'b1;
          tx_er_d[p]      = 1'b1;
          txd_d[8*p +: 8] = `RPT_ERR_CODE;
        end else begin
          tx_en_d[p]      = dv[src_d];
          tx_er_d[p]      = er[src_d];
          txd_d[8*p +: 8] = data[8*src_d +: 8];
        end
      end
    end
  end

  // fixed pipeline depth keeps start delay constant from packet to packet
  always @(posedge sys_clk) begin
    if (srst) begin
      tx_en_q     <= {NPORT{1'b0}};
      tx_er_q     <= {NPORT{1'b0}};
      txd_q       <= {(8*NPORT){1'b0}};
      fwd_only_q  <= {NPORT{`RPT_FWD_ONLY_RST}};
      collision_q <= 1'b0;
      busy_q      <= 1'b0;
    end else begin
      tx_en_q     <= tx_en_d;
      tx_er_q     <= tx_er_d;
      txd_q       <= txd_d;
      fwd_only_q  <= {NPORT{1'b1}};
      collision_q <= (st_d == `RPT_ST_JAM);
      busy_q      <= (st_d != `RPT_ST_IDLE);
    end
  end

endmodule
`default_nettype wire

/* rpt_map.vh */
// constants shared by the repeater core and its receive stage
// assumes all ports and the core share sys_clk; no file includes this twice without the guard
`ifndef RPT_MAP_VH
`define RPT_MAP_VH

// ----------------------------------------------------------------------------
// code-groups placed on the transmit bytes and the receive-stage reset byte
// ----------------------------------------------------------------------------
`define RPT_JAM_CODE      8'h55
`define RPT_ERR_CODE      8'h1F
`define RPT_IDLE_CODE     8'h00

// ----------------------------------------------------------------------------
// core states
// ----------------------------------------------------------------------------
`define RPT_ST_IDLE       2'h0
`define RPT_ST_FWD        2'h1
`define RPT_ST_JAM        2'h2

// ----------------------------------------------------------------------------
// timing, in bit times, picoseconds, nanoseconds and clock cycles
// ----------------------------------------------------------------------------
`define RPT_BT_PS         1000
`define RPT_CLK_NS        100
`define RPT_SOP_SOJ_BT    976
`define RPT_SOP_VAR_BT    16
`define RPT_PRE_VAR_BT    8
`define RPT_PIPE_CYC      2
// longest allowed start delay in whole cycles, rounded down, at least one
`define RPT_SOP_MAX_CYC   ((`RPT_SOP_SOJ_BT * `RPT_BT_PS) / (`RPT_CLK_NS * 1000) < 1 ? 1 : \
                           (`RPT_SOP_SOJ_BT * `RPT_BT_PS) / (`RPT_CLK_NS * 1000))

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RPT_FWD_ONLY_RST  1'b0

`endif

/* rpt_rx_port.v */
// receive stage of one repeater port: registers the byte stream from the port phy
// assumes the phy receive signals are already on sys_clk (common symbol clock)
`timescale 1ns/1ps
`default_nettype none
`include "rpt_map.vh"

module rpt_rx_port (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire       rx_dv,
  input  wire       rx_er,
  input  wire [7:0] rxd,
  output reg        dv_q,
  output reg        er_q,
  output reg        act_q,
  output reg  [7:0] data_q
);

  // --------------------------------------------------------------------------
  // capture
  // --------------------------------------------------------------------------
  // carrier without data (false carrier, extension) still counts as activity
  always @(posedge sys_clk) begin
    if (srst) begin
      dv_q   <= 1'b0;
      er_q   <= 1'b0;
      act_q  <= 1'b0;
      data_q <= `RPT_IDLE_CODE;
    end else begin
      dv_q   <= rx_dv;
      er_q   <= rx_er;
      act_q  <= rx_dv | rx_er;
      data_q <= rxd;
    end
  end

endmodule
`default_nettype wire

/* rpt_phy_model.sv */
// port phy model: sends one frame per call on the gmii-style receive side
// assumes the core samples rx on the rising edge of sys_clk
`timescale 1ns/1ps
`default_nettype none

module rpt_phy_model #(
  parameter NPORT = 4
) (
  input  wire logic               sys_clk,
  output var  logic [NPORT-1:0]   rx_dv,
  output var  logic [NPORT-1:0]   rx_er,
  output var  logic [8*NPORT-1:0] rxd
);
  initial begin
    rx_dv = '0;
    rx_er = '0;
    rxd = '0;
  end

  // bad: byte index carrying a code violation, -2 for carrier without data
  task automatic send(input int p, input int n, input int bad);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      rx_dv[p] <= (bad != -2);
      rx_er[p] <= (bad == -2) || (i == bad);
      rxd[8*p+:8] <= (i < 7) ? 8'h55 : (i == 7) ? 8'hD5 : 8'(16 * p + i);
    end
    @(posedge sys_clk);
    rx_dv[p] <= 1'b0;
    rx_er[p] <= 1'b0;
    // released byte lane shows garbage, not the last byte
    rxd[8*p+:8] <= ~rxd[8*p+:8];
  endtask
endmodule
`default_nettype wire

/* rpt_core_props.sv */
// checker for the repeater core, bound to its ports
// assumes the fixed 2-cycle rx to tx latency of the core
`timescale 1ns/1ps
`default_nettype none
`include "rpt_map.vh"

module rpt_core_props #(
  parameter NPORT = 4
) (
  input wire logic               sys_clk,
  input wire logic               srst,
  input wire logic [NPORT-1:0]   rx_dv,
  input wire logic [NPORT-1:0]   rx_er,
  input wire logic [8*NPORT-1:0] rxd,
  input wire logic [NPORT-1:0]   tx_en_q,
  input wire logic [NPORT-1:0]   tx_er_q,
  input wire logic [8*NPORT-1:0] txd_q,
  input wire logic [NPORT-1:0]   fwd_only_q,
  input wire logic               collision_q,
  input wire logic               busy_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire logic [NPORT-1:0] act = rx_dv | rx_er;
  sequence s_quiet2;
    act == '0 [*2];
  endsequence
  sequence s_lone;
    $onehot(rx_dv) && rx_er == '0;
  endsequence
  sequence s_err_tx;
    (tx_en_q & tx_er_q) != '0 && !collision_q;
  endsequence
  sequence s_tx_on;
    tx_en_q != '0 && !collision_q;
  endsequence

  chk_fwd_start: assert property (s_quiet2 ##1 s_lone |-> ##2 busy_q && tx_en_q == ~$past(rx_dv, 2))
    else $error("start");
  chk_collide_seen: assert property ($countones(act) > 1 |-> ##2 collision_q)
    else $error("collision");
  chk_jam_out: assert property (collision_q |-> tx_en_q == '1 && txd_q == {NPORT{`RPT_JAM_CODE}})
    else $error("jam");
  chk_jam_stop: assert property (collision_q ##0 s_quiet2 |-> ##1 !collision_q && tx_en_q == '0)
    else $error("jam end");
  chk_err_mark: assert property ($past(rx_dv & rx_er, 2) != '0 && !collision_q |-> tx_er_q == tx_en_q)
    else $error("error mark");
  chk_err_sticky: assert property (s_err_tx ##1 s_tx_on |-> tx_er_q == tx_en_q)
    else $error("error sticky");
  chk_fwd_only: assert property (!$past(srst) |-> fwd_only_q == '1)
    else $error("fwd only");
  chk_reset_clear: assert property (disable iff (1'b0) srst |=> tx_en_q == '0 && !busy_q && !collision_q)
    else $error("reset");
endmodule
`default_nettype wire

/* rpt_core_tb.sv */
// testbench for the repeater core: phy model drives rx, scenarios judge tx
// assumes a 4-port core on one 10 MHz clock with synchronous reset
`timescale 1ns/1ps
`default_nettype none
`include "rpt_map.vh"

module rpt_core_tb;
  localparam NP = 4;
  logic            sys_clk = 1'b0;
  logic            srst = 1'b1;
  logic [NP-1:0]   rx_dv, rx_er, tx_en_q, tx_er_q, fwd_only_q, dv1, dv2, er1, er2;
  logic [8*NP-1:0] rxd, txd_q, rxd1, rxd2;
  logic            collision_q, busy_q, st;
  int              n_fail = 0, comparisons = 0, cyc = 0;

  always #50 sys_clk = ~sys_clk;
  // rx copy delayed to line up with the 2-cycle tx latency
  always @(posedge sys_clk) begin
    {dv2, er2, rxd2, dv1, er1, rxd1} <= {dv1, er1, rxd1, rx_dv, rx_er, rxd};
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      end_sim;
    end
  end

  rpt_phy_model #(.NPORT(NP)) i_rpt_phy_model (.sys_clk(sys_clk), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd));
  rpt_core #(.NPORT(NP)) i_rpt_core (.sys_clk(sys_clk), .srst(srst), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd),
    .tx_en_q(tx_en_q), .tx_er_q(tx_er_q), .txd_q(txd_q), .fwd_only_q(fwd_only_q), .collision_q(collision_q),
    .busy_q(busy_q));

  task end_sim;
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask

  // one port's frame seen two cycles late; after a violation the rest is substituted
  task chk_fwd(input int p);
    st = dv2[p] && (st || er2[p]);
    for (int q = 0; q < NP; q++) begin
      cmp("tx_en", (q != p) && dv2[p], tx_en_q[q]);
      cmp("tx_er", (q != p) && (st || er2[p]), tx_er_q[q]);
      if (q != p && dv2[p])
        cmp("txd", st ? `RPT_ERR_CODE : rxd2[8*p+:8], txd_q[8*q+:8]);
    end
  endtask

  task run(input int p, input int n, input int bad);
    st = 1'b0;
    fork
      i_rpt_phy_model.send(p, n, bad);
    join_none
    repeat (n + 4) begin
      @(negedge sys_clk);
      chk_fwd(p);
    end
  endtask

  // first edge after release still shows reset values, the second the forward-only setting
  task t_reset;
    @(negedge sys_clk);
    cmp("fwd_only", '0, fwd_only_q);
    @(negedge sys_clk);
    cmp("fwd_only", {NP{1'b1}}, fwd_only_q);
    cmp("busy", 1'b0, busy_q);
  endtask

  task t_fwd_all;
    for (int p = 0; p < NP; p++)
      run(p, 12, -1);
  endtask

  // violation at byte 9: that byte and the rest go out as the error code-group
  task t_code_err;
    run(1, 14, 9);
  endtask

  // carrier without data is repeated as error without enable
  task t_carrier;
    run(2, 6, -2);
  endtask

  // second port joins at its 9th edge; jam two cycles later, held until all ports are quiet
  task t_collide;
    fork
      i_rpt_phy_model.send(0, 20, -1);
      begin
        repeat (8) @(posedge sys_clk);
        i_rpt_phy_model.send(3, 6, -1);
      end
      begin
        repeat (10) @(negedge sys_clk);
        cmp("coll", 1'b0, collision_q);
        @(negedge sys_clk);
        cmp("coll", 1'b1, collision_q);
        cmp("jam_d", {NP{`RPT_JAM_CODE}}, txd_q);
        cmp("jam_er", '0, tx_er_q);
        cmp("busy", 1'b1, busy_q);
      end
    join
    repeat (2) @(negedge sys_clk);
    cmp("coll", 1'b1, collision_q);
    @(negedge sys_clk);
    cmp("coll", 1'b0, collision_q);
    cmp("tx_en", '0, tx_en_q);
  endtask

  // reset in mid-frame clears the outputs; forwarding picks the frame up after release
  task t_reset_mid;
    fork
      i_rpt_phy_model.send(0, 12, -1);
    join_none
    repeat (5) @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(negedge sys_clk);
    cmp("tx_en", '0, tx_en_q);
    cmp("busy", 1'b0, busy_q);
    cmp("coll", 1'b0, collision_q);
    @(posedge sys_clk);
    srst <= 1'b0;
    repeat (2) @(negedge sys_clk);
    cmp("tx_en", '0, tx_en_q);
    cmp("fwd_only", {NP{1'b1}}, fwd_only_q);
    @(negedge sys_clk);
    cmp("tx_en", 4'hE, tx_en_q);
    cmp("busy", 1'b1, busy_q);
    repeat (6) @(negedge sys_clk);
    cmp("tx_en", '0, tx_en_q);
    cmp("busy", 1'b0, busy_q);
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset;
    t_fwd_all;
    t_code_err;
    t_carrier;
    t_collide;
    t_reset_mid;
    end_sim;
  end
endmodule

bind rpt_core rpt_core_props #(.NPORT(NPORT)) i_rpt_core_props (.sys_clk(sys_clk), .srst(srst), .rx_dv(rx_dv),
  .rx_er(rx_er), .rxd(rxd), .tx_en_q(tx_en_q), .tx_er_q(tx_er_q), .txd_q(txd_q), .fwd_only_q(fwd_only_q),
  .collision_q(collision_q), .busy_q(busy_q));
`default_nettype wire
